// >>> async_serial_transceiver.sv
// Asynchronous serial transceiver: registers, baud generators, transmitter, receiver
`default_nettype none
module async_serial_transceiver #(
  parameter int ADDR_W = 3
) (
  input  wire logic              clk,            // 100 MHz clock
  input  wire logic              rstn,           // Async reset, active low
  input  wire logic [ADDR_W-1:0] addr,           // Register index
  input  wire logic [7:0]        wdata,          // Write data
  input  wire logic              wr,             // Write strobe
  input  wire logic              rd,             // Read strobe
  output logic      [7:0]        rdata,          // Read data, cycle after rd
  input  wire logic              cpu_irq_mask,   // CPU interrupt mask bit
  input  wire logic              serial_in_pin,  // Receive line
  output logic                   tx_pin,         // Transmit line
  output logic                   tx_pin_oe,      // Tx line driven
  output logic                   irq             // Interrupt request
);
  // Control and configuration registers
  logic [7:0] ctl1_q, ctl2_q, baud_q, tdr_q, rdr_q, rdata_q;
  logic       r8_q, seen_q, irq_q;
  logic       tx_buffer_empty_flag_q, tc_q, rx_full_flag_q, idle_q, ovr_q, nf_q, fe_q;
  logic       word9, tx_on, rx_on, send_break_ctl;
  assign word9 = ctl1_q[serial_pkg::C1_M];
  assign tx_on = ctl2_q[serial_pkg::C2_TE];
  assign rx_on = ctl2_q[serial_pkg::C2_RE];
  assign send_break_ctl   = ctl2_q[serial_pkg::C2_SBK];

  // Bus decode
  logic wr_data, rd_data, clr_tx, clr_rx;
  assign wr_data = wr && (addr == serial_pkg::ADDR_DATA);
  assign rd_data = rd && (addr == serial_pkg::ADDR_DATA);
  assign clr_tx  = wr_data && seen_q;
  assign clr_rx  = rd_data && seen_q;

  // Rate limit: prescaler times power of two, minus one
  function automatic logic [10:0] baud_limit(input logic [1:0] p, input logic [2:0] d);
    logic [10:0] pr;
    pr = serial_pkg::PRE_1;
    unique case (p)
      2'h0: pr = serial_pkg::PRE_1;
      2'h1: pr = serial_pkg::PRE_3;
      2'h2: pr = serial_pkg::PRE_4;
      2'h3: pr = serial_pkg::PRE_13;
    endcase
    baud_limit = (pr << d) - 11'h001;
  endfunction

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Sixteen-times sample ticks, tx and rx independent
  logic [10:0] tx_cnt_q, rx_cnt_q, tx_lim, rx_lim;
  logic        tx_tick, rx_tick;
  assign tx_lim  = baud_limit(baud_q[serial_pkg::BD_PR_LO +: 2],
                              baud_q[serial_pkg::BD_TR_LO +: 3]);
  assign rx_lim  = baud_limit(baud_q[serial_pkg::BD_PR_LO +: 2],
                              baud_q[serial_pkg::BD_RR_LO +: 3]);
  assign tx_tick = (tx_cnt_q >= tx_lim);
  assign rx_tick = (rx_cnt_q >= rx_lim);

  // Free-running dividers; changing rates while enabled glitches a bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_cnt_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      tx_cnt_q <= tx_tick ? '0 : tx_cnt_q + 11'h001;
      rx_cnt_q <= rx_tick ? '0 : rx_cnt_q + 11'h001;
    end
  end

  // Transmitter state
  serial_pkg::tx_state_t tx_state_q;
  logic [10:0] tx_sh_q;
  logic [3:0]  tx_ph_q, tx_bit_q, tx_last;
  logic        tx_brk_q, tdr_full_q, idle_pend_q, tx_on_prev_q, tx_out_q;
  logic        bit_end, frame_end, slot, te_rise;
  logic        go_mark, take_brk, take_idle, take_tdr, take_dir, launch;
  logic [10:0] load_val;
  assign tx_last   = word9 ? serial_pkg::LAST_BIT_9 : serial_pkg::LAST_BIT_8;
  assign bit_end   = tx_tick && (tx_ph_q == serial_pkg::PH_LAST);
  assign frame_end = bit_end && ((tx_state_q == serial_pkg::TX_MARK) ||
                     ((tx_state_q == serial_pkg::TX_SHIFT) && (tx_bit_q == tx_last)));
  assign slot      = tx_on && ((tx_state_q == serial_pkg::TX_IDLE) || frame_end);
  assign te_rise   = tx_on && !tx_on_prev_q;

  // Next frame choice: break, then idle, then buffer, then a direct write
  always_comb begin
    go_mark   = frame_end && tx_brk_q && !send_break_ctl &&
                (tx_state_q == serial_pkg::TX_SHIFT);
    take_brk  = 1'b0;
    take_idle = 1'b0;
    take_tdr  = 1'b0;
    take_dir  = 1'b0;
    load_val  = '1;
    if (slot && !go_mark) begin
      if (send_break_ctl) begin
        take_brk = 1'b1;
        load_val = '0;
      end else if (idle_pend_q) begin
        take_idle = 1'b1;
        load_val  = '1;
      end else if (tdr_full_q) begin
        take_tdr = 1'b1;
        load_val = {1'b1, ctl1_q[serial_pkg::C1_T8], tdr_q, 1'b0};
      end else if (wr_data && (tx_state_q == serial_pkg::TX_IDLE)) begin
        take_dir = 1'b1;
        load_val = {1'b1, ctl1_q[serial_pkg::C1_T8], wdata, 1'b0};
      end
    end
    if (!word9) begin
      load_val[9] = load_val[10];                       // Stop sits after bit 8
    end
    launch = take_brk || take_idle || take_tdr || take_dir;
  end

  // Transmit sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_q <= serial_pkg::TX_IDLE;
      tx_sh_q    <= '1;
      tx_ph_q    <= '0;
      tx_bit_q   <= '0;
      tx_brk_q   <= 1'b0;
    end else begin
      if (tx_tick) begin
        tx_ph_q <= tx_ph_q + 4'h1;
      end
      if (launch) begin
        tx_state_q <= serial_pkg::TX_SHIFT;
        tx_sh_q    <= load_val;
        tx_ph_q    <= '0;
        tx_bit_q   <= '0;
        tx_brk_q   <= take_brk;
      end else if (go_mark) begin
        tx_state_q <= serial_pkg::TX_MARK;
        tx_ph_q    <= '0;
        tx_brk_q   <= 1'b0;
      end else if (frame_end) begin
        tx_state_q <= serial_pkg::TX_IDLE;
        tx_brk_q   <= 1'b0;
      end else if (bit_end && (tx_state_q == serial_pkg::TX_SHIFT)) begin
        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
      end
    end
  end

  // Line level: shifter bit while sending, mark otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_out_q <= 1'b1;
    end else if (tx_state_q == serial_pkg::TX_SHIFT) begin
      tx_out_q <= tx_sh_q[0];
    end else begin
      tx_out_q <= 1'b1;
    end
  end

  // Transmit buffer and pending idle frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tdr_q        <= '0;
      tdr_full_q   <= 1'b0;
      idle_pend_q  <= 1'b0;
      tx_on_prev_q <= 1'b0;
    end else begin
      tx_on_prev_q <= tx_on;
      if (wr_data) begin
        tdr_q <= wdata;
      end
      if (wr_data && !take_dir) begin
        tdr_full_q <= 1'b1;
      end else if (take_tdr || te_rise) begin
        tdr_full_q <= 1'b0;
      end
      if (te_rise) begin
        idle_pend_q <= 1'b1;
      end else if (take_idle) begin
        idle_pend_q <= 1'b0;
      end
    end
  end

  // Transmit flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_buffer_empty_flag_q <= 1'b1;
      tc_q   <= 1'b1;
    end else begin
      if (take_tdr || take_dir) begin
        tx_buffer_empty_flag_q <= 1'b1;
      end else if (clr_tx) begin
        tx_buffer_empty_flag_q <= 1'b0;
      end
      if (frame_end) begin
        tc_q <= 1'b1;
      end else if (clr_tx) begin
        tc_q <= 1'b0;
      end
    end
  end

  // Receive line synchroniser
  logic rx_meta_q, rx_s_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_meta_q <= 1'b1;
      rx_s_q    <= 1'b1;
    end else begin
      rx_meta_q <= serial_in_pin;
      rx_s_q    <= rx_meta_q;
    end
  end

  // Receiver state
  serial_pkg::rx_state_t rx_state_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_ph_q, rx_bit_q, rx_ndata;
  logic [2:0] rx_hist_q;
  logic [7:0] idle_cnt_q, idle_tk;
  logic       s8_q, s9_q, rx_nz_q, nz_hold_q, idle_arm_q;
  logic       at_s10, mval, mdis, rx_done, rx_fe, rx_nz, rx_false, idle_hit;
  assign rx_ndata = word9 ? serial_pkg::NDATA_9 : serial_pkg::NDATA_8;
  assign idle_tk  = word9 ? serial_pkg::IDLE_TK_9 : serial_pkg::IDLE_TK_8;
  assign at_s10   = rx_tick && (rx_ph_q == serial_pkg::PH_S10);
  assign mval     = maj3(s8_q, s9_q, rx_s_q);
  assign mdis     = !((s8_q == s9_q) && (s9_q == rx_s_q));
  assign rx_false = at_s10 && (rx_state_q == serial_pkg::RX_START) && mval;
  assign rx_done  = at_s10 && (rx_state_q == serial_pkg::RX_DATA) &&
                    (rx_bit_q == rx_ndata);
  assign rx_fe    = !mval;
  assign rx_nz    = rx_nz_q || mdis || nz_hold_q;
  assign idle_hit = rx_on && idle_arm_q && (idle_cnt_q == idle_tk);

  // Receive sequencer, sixteen samples per bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state_q <= serial_pkg::RX_HUNT;
      rx_hist_q  <= '0;
      rx_ph_q    <= '0;
      rx_bit_q   <= '0;
      rx_sh_q    <= '0;
      s8_q       <= 1'b0;
      s9_q       <= 1'b0;
      rx_nz_q    <= 1'b0;
    end else if (!rx_on) begin
      rx_state_q <= serial_pkg::RX_HUNT;
      rx_hist_q  <= '0;                                  // Needs a one before an edge
    end else if (rx_tick) begin
      rx_ph_q <= rx_ph_q + 4'h1;
      if (rx_ph_q == serial_pkg::PH_S8) begin
        s8_q <= rx_s_q;
      end
      if (rx_ph_q == serial_pkg::PH_S9) begin
        s9_q <= rx_s_q;
      end
      unique case (rx_state_q)
        serial_pkg::RX_HUNT: begin
          rx_hist_q <= {rx_hist_q[1:0], rx_s_q};
          if (!rx_s_q && rx_hist_q[0]) begin
            rx_state_q <= serial_pkg::RX_START;
            rx_ph_q    <= 4'h1;                          // Edge is sample one
            rx_nz_q    <= (rx_hist_q != 3'b111);
          end
        end
        serial_pkg::RX_START: begin
          if (rx_s_q && ((rx_ph_q == serial_pkg::PH_S3) || (rx_ph_q == serial_pkg::PH_S5) ||
                         (rx_ph_q == serial_pkg::PH_S7))) begin
            rx_nz_q <= 1'b1;
          end
          if (at_s10) begin
            if (mval) begin
              rx_state_q <= serial_pkg::RX_HUNT;
              rx_hist_q  <= 3'b111;
            end else begin
              rx_state_q <= serial_pkg::RX_DATA;
              rx_bit_q   <= '0;
              rx_nz_q    <= rx_nz_q || mdis;
            end
          end
        end
        serial_pkg::RX_DATA: begin
          if (at_s10) begin
            if (rx_bit_q == rx_ndata) begin
              rx_state_q <= serial_pkg::RX_HUNT;         // Stop sampled mid-bit
              rx_hist_q  <= {3{mval}};
            end else begin
              rx_sh_q  <= {mval, rx_sh_q[8:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              rx_nz_q  <= rx_nz_q || mdis;
            end
          end
        end
      endcase
    end
  end

  // Idle frame detector, armed by enable or after a character
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_q <= '0;
      idle_arm_q <= 1'b0;
    end else begin
      if (!rx_on || (rx_state_q != serial_pkg::RX_HUNT) || !rx_s_q) begin
        idle_cnt_q <= '0;
      end else if (rx_tick && (idle_cnt_q != idle_tk)) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end
      if (!rx_on || rx_done) begin
        idle_arm_q <= 1'b1;
      end else if (idle_hit) begin
        idle_arm_q <= 1'b0;
      end
    end
  end

  // Receive buffer and flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdr_q     <= '0;
      r8_q      <= 1'b0;
      rx_full_flag_q    <= 1'b0;
      ovr_q     <= 1'b0;
      nf_q      <= 1'b0;
      fe_q      <= 1'b0;
      idle_q    <= 1'b0;
      nz_hold_q <= 1'b0;
    end else begin
      if (rx_false) begin
        nz_hold_q <= 1'b1;
      end else if (rx_done && !rx_full_flag_q) begin
        nz_hold_q <= 1'b0;
      end
      if (rx_done && !rx_full_flag_q) begin
        rdr_q  <= word9 ? rx_sh_q[7:0] : rx_sh_q[8:1];
        r8_q   <= word9 & rx_sh_q[8];
        rx_full_flag_q <= 1'b1;
        nf_q   <= rx_nz;
        fe_q   <= rx_fe;
      end else if (clr_rx) begin
        rx_full_flag_q <= 1'b0;
        nf_q   <= 1'b0;
        fe_q   <= 1'b0;
      end
      if (rx_done && rx_full_flag_q) begin
        ovr_q <= 1'b1;
      end else if (clr_rx) begin
        ovr_q <= 1'b0;
      end
      if (idle_hit) begin
        idle_q <= 1'b1;
      end else if (clr_rx) begin
        idle_q <= 1'b0;
      end
    end
  end

  // Register writes and the status-access latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl1_q <= serial_pkg::RST_CTL;
      ctl2_q <= serial_pkg::RST_CTL;
      baud_q <= serial_pkg::RST_BAUD;
      seen_q <= 1'b0;
    end else begin
      if (wr && (addr == serial_pkg::ADDR_CTL1)) begin
        ctl1_q <= wdata;
      end
      if (wr && (addr == serial_pkg::ADDR_CTL2)) begin
        ctl2_q <= wdata;
      end
      if (wr && (addr == serial_pkg::ADDR_BAUD)) begin
        baud_q <= wdata;
      end
      if ((rd || wr) && (addr == serial_pkg::ADDR_STATUS)) begin
        seen_q <= 1'b1;
      end else if (rd_data || wr_data) begin
        seen_q <= 1'b0;
      end
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else if (rd) begin
      rdata_q <= '0;
      unique case (addr)
        serial_pkg::ADDR_STATUS: rdata_q <= {tx_buffer_empty_flag_q, tc_q, rx_full_flag_q, idle_q,
                                             ovr_q, nf_q, fe_q, 1'b0};
        serial_pkg::ADDR_DATA:   rdata_q <= rdr_q;
        serial_pkg::ADDR_CTL1: begin
          rdata_q <= ctl1_q;
          rdata_q[serial_pkg::C1_R8] <= r8_q;
        end
        serial_pkg::ADDR_CTL2:   rdata_q <= ctl2_q;
        serial_pkg::ADDR_BAUD:   rdata_q <= baud_q;
        default:                 rdata_q <= '0;
      endcase
    end
  end

  // Interrupt request, registered; noise and framing have no own source
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= !cpu_irq_mask &&
               ((tx_buffer_empty_flag_q && ctl2_q[serial_pkg::C2_TIE]) ||
                (tc_q && ctl2_q[serial_pkg::C2_TX_DONE_IRQ_ON]) ||
                ((rx_full_flag_q || ovr_q) && ctl2_q[serial_pkg::C2_RIE]) ||
                (idle_q && ctl2_q[serial_pkg::C2_IDLE_IRQ_ON]));
    end
  end

  assign rdata     = rdata_q;
  assign tx_pin    = tx_out_q;
  assign tx_pin_oe = tx_on || rx_on;
  assign irq       = irq_q;
endmodule
`default_nettype wire

// >>> async_serial_transceiver_checker.sv
// Port checker for the serial transceiver, bound to its top module
`default_nettype none
module serial_port_checker (
  input wire logic       clk,          // Clock
  input wire logic       rstn,         // Reset, active low
  input wire logic [2:0] addr,         // Register index
  input wire logic [7:0] wdata,        // Write data
  input wire logic       wr,           // Write strobe
  input wire logic       rd,           // Read strobe
  input wire logic [7:0] rdata,        // Read data
  input wire logic       cpu_irq_mask, // Interrupt mask
  input wire logic       tx_pin,       // Transmit line
  input wire logic       tx_pin_oe,    // Line driven
  input wire logic       irq           // Interrupt request
);
  logic [7:0] ctl1_q, ctl2_q, baud_q;
  // Shadow of the writable registers, so read-back and enables can be judged
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl1_q <= serial_pkg::RST_CTL;
      ctl2_q <= serial_pkg::RST_CTL;
      baud_q <= serial_pkg::RST_BAUD;
    end else if (wr) begin
      if (addr == serial_pkg::ADDR_CTL1) ctl1_q <= wdata;
      if (addr == serial_pkg::ADDR_CTL2) ctl2_q <= wdata;
      if (addr == serial_pkg::ADDR_BAUD) baud_q <= wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Interrupt, line levels and read-back; each tx line level must hold for at least 8 clocks
  a_irq_masked: assert property (cpu_irq_mask |=> !irq)
    else $error("irq raised while masked");
  a_irq_cause: assert property (irq |-> $past(ctl2_q[7:4]) != 4'h0)
    else $error("irq without an enabled source");
  a_start_low: assert property ($fell(tx_pin) |-> (!tx_pin)[*8])
    else $error("low level on tx line too short");
  a_bit_length: assert property ($rose(tx_pin) |-> tx_pin[*8])
    else $error("high level on tx line too short");
  a_reset_idle: assert property ($rose(rstn) |-> tx_pin && !irq)
    else $error("tx line not idle after reset");
  a_oe_follows: assert property (tx_pin_oe == (ctl2_q[3] | ctl2_q[2]))
    else $error("tx line drive differs from enables");
  a_baud_back: assert property (rd && addr == serial_pkg::ADDR_BAUD |=> rdata == $past(baud_q))
    else $error("baud select read-back wrong");
  a_ninth_store: assert property (
      rd && addr == serial_pkg::ADDR_CTL1 |=> rdata[6:0] == $past(ctl1_q[6:0]))
    else $error("control one read-back wrong");
  cover property (rd && addr == serial_pkg::ADDR_STATUS);
  cover property ($fell(tx_pin));
  cover property (irq);
endmodule
bind async_serial_transceiver serial_port_checker i_chk (.clk(clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cpu_irq_mask(cpu_irq_mask),
  .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .irq(irq));
`default_nettype wire

// >>> serial_far_end.sv
// Remote serial device model: sends frames into the block, captures its frames
`default_nettype none
module serial_far_end (
  input  wire logic clk,     // Clock shared with the block
  input  wire logic rx_line, // Transmit line of the block
  output var  logic tx_line  // Receive line of the block, idle high
);
  timeunit 1ns;
  timeprecision 1ps;
  initial tx_line = 1'b1;
  // One frame at 16 clocks a bit; a glitch inverts the ninth sample of data bit 0
  task automatic send(input logic [8:0] d, input int n, input logic stp, input logic g);
    logic b;
    for (int i = 0; i < n + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : stp;
      for (int j = 0; j < 16; j++) begin
        @(posedge clk);
        tx_line <= b ^ (g && i == 1 && j == 8);
      end
    end
    @(posedge clk);
    tx_line <= 1'b1;
  endtask
  // Capture a frame mid-bit on the falling edge, so the sample never races the launch
  task automatic recv(input int n, output logic [8:0] d, output logic stp, output int w);
    d = 9'h000;
    for (w = 0; w < 2000 && rx_line !== 1'b0; w++) @(negedge clk);
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(negedge clk);
      d[i] = rx_line;
    end
    repeat (16) @(negedge clk);
    stp = rx_line;
  endtask
endmodule
`default_nettype wire

// >>> serial_pkg.sv
// Constants shared by the asynchronous serial transceiver
`default_nettype none
package serial_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_DATA   = 3'h1;
  localparam logic [2:0] ADDR_CTL1   = 3'h2;
  localparam logic [2:0] ADDR_CTL2   = 3'h3;
  localparam logic [2:0] ADDR_BAUD   = 3'h4;
  // Status bit positions
  localparam int ST_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int ST_TC   = 6;
  localparam int ST_RX_FULL_FLAG = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVR  = 3;
  localparam int ST_NF   = 2;
  localparam int ST_FE   = 1;
  // Control one bit positions
  localparam int C1_R8 = 7;
  localparam int C1_T8 = 6;
  localparam int C1_M  = 4;
  // Control two bit positions
  localparam int C2_TIE  = 7;
  localparam int C2_TX_DONE_IRQ_ON = 6;
  localparam int C2_RIE  = 5;
  localparam int C2_IDLE_IRQ_ON = 4;
  localparam int C2_TE   = 3;
  localparam int C2_RE   = 2;
  localparam int C2_SBK  = 0;
  // Baud select field positions
  localparam int BD_PR_LO = 6;
  localparam int BD_TR_LO = 3;
  localparam int BD_RR_LO = 0;
  // Prescaler values
  localparam logic [10:0] PRE_1  = 11'h001;
  localparam logic [10:0] PRE_3  = 11'h003;
  localparam logic [10:0] PRE_4  = 11'h004;
  localparam logic [10:0] PRE_13 = 11'h00d;
  // Frame and sampling figures
  localparam logic [3:0] LAST_BIT_8 = 4'h9;   // Start, 8 data, stop
  localparam logic [3:0] LAST_BIT_9 = 4'ha;   // Start, 9 data, stop
  localparam logic [3:0] NDATA_8    = 4'h8;
  localparam logic [3:0] NDATA_9    = 4'h9;
  localparam logic [3:0] PH_LAST    = 4'hf;   // Sixteen samples per bit
  localparam logic [3:0] PH_S3      = 4'h2;
  localparam logic [3:0] PH_S5      = 4'h4;
  localparam logic [3:0] PH_S7      = 4'h6;
  localparam logic [3:0] PH_S8      = 4'h7;
  localparam logic [3:0] PH_S9      = 4'h8;
  localparam logic [3:0] PH_S10     = 4'h9;
  localparam logic [7:0] IDLE_TK_8  = 8'ha0;  // 10 bits of 16 samples
  localparam logic [7:0] IDLE_TK_9  = 8'hb0;  // 11 bits of 16 samples
  // Reset values
  localparam logic [7:0] RST_CTL    = 8'h00;
  localparam logic [7:0] RST_BAUD   = 8'h00;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_MARK  = 3'b100
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_HUNT  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } rx_state_t;
endpackage
`default_nettype wire

// >>> test_async_serial_transceiver.sv
// Self-checking bench for the asynchronous serial transceiver
`default_nettype none
module test_async_serial_transceiver;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] AS = serial_pkg::ADDR_STATUS;
  localparam logic [2:0] AD = serial_pkg::ADDR_DATA;
  localparam logic [2:0] A1 = serial_pkg::ADDR_CTL1;
  localparam logic [2:0] A2 = serial_pkg::ADDR_CTL2;
  localparam logic [2:0] AB = serial_pkg::ADDR_BAUD;
  logic       clk, rstn, wr, rd, cpu_irq_mask, serial_in_pin, tx_pin, tx_pin_oe, irq;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  int         n_mismatch, compares;
  async_serial_transceiver i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cpu_irq_mask(cpu_irq_mask),
    .serial_in_pin(serial_in_pin), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .irq(irq));
  serial_far_end i_far (.clk(clk), .rx_line(tx_pin), .tx_line(serial_in_pin));
  // Compare, count and report
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Register port cycles; read data is taken mid-cycle after the strobe
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Frame capture with a bounded wait
  task automatic grab(input int n, output logic [8:0] d, output logic s, output int w);
    i_far.recv(n, d, s, w);
    if (w >= 2000) begin
      check(1'b0, 1'b1);
      final_report();
    end
  endtask
  // Receive one frame and read status then data, which also clears the flags
  task automatic rx_one(input logic [8:0] d, input int n, input logic stp, input logic g,
                        input logic [7:0] est, input logic [7:0] ed);
    logic [7:0] v;
    i_far.send(d, n, stp, g);
    repeat (4) @(negedge clk);
    get(AS, v);
    check(v & 8'h2e, est);
    get(AD, v);
    check(v, ed);
  endtask
  task automatic t_reset();
    logic [7:0] v;
    get(AS, v);
    check(v, 8'hc0);
    get(AB, v);
    check(v, 8'h00);
    get(3'h7, v);
    check(v, 8'h00);
  endtask
  task automatic t_tx();
    logic [7:0] v;
    logic [8:0] d;
    logic       s;
    int         w;
    int         n;
    put(AB, 8'h00);
    put(A2, 8'h08);
    get(AS, v);
    put(AD, 8'ha5);
    get(AS, v);
    check(v[7:6], 2'b00);
    grab(8, d, s, w);
    check(w > 140, 1'b1);
    check(d, 9'h0a5);
    check(s, 1'b1);
    repeat (16) @(negedge clk);
    get(AS, v);
    check(v[7:6], 2'b11);
    put(A1, 8'h50);
    get(AS, v);
    put(AD, 8'h3c);
    get(AS, v);
    check(v[7:6], 2'b10);
    put(AD, 8'h81);
    grab(9, d, s, w);
    check(d, 9'h13c);
    grab(9, d, s, w);
    check(d, 9'h181);
    put(A2, 8'h09);
    repeat (200) @(negedge clk);
    check(tx_pin, 1'b0);
    // A byte queued during break must wait for the one extra mark bit
    put(AD, 8'h5a);
    put(A2, 8'h08);
    for (w = 0; w < 400 && tx_pin !== 1'b1; w++) @(negedge clk);
    for (n = 0; n < 40 && tx_pin === 1'b1; n++) @(negedge clk);
    check(n, 9'h010);
    grab(9, d, s, w);
    check(d, 9'h15a);
    repeat (16) @(negedge clk);
    // Toggling the enable mid-frame drops the queued byte behind an idle frame
    put(AD, 8'h66);
    put(AD, 8'h99);
    put(A2, 8'h00);
    put(A2, 8'h08);
    grab(9, d, s, w);
    check(d, 9'h166);
    for (w = 0; w < 400 && tx_pin === 1'b1; w++) @(negedge clk);
    check(w == 400, 1'b1);
  endtask
  task automatic t_rx();
    logic [7:0] v;
    put(A1, 8'h00);
    put(A2, 8'h24);
    i_far.send(9'h011, 8, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    check(irq, 1'b1);
    @(posedge clk);
    cpu_irq_mask <= 1'b1;
    repeat (2) @(negedge clk);
    check(irq, 1'b0);
    @(posedge clk);
    cpu_irq_mask <= 1'b0;
    rx_one(9'h022, 8, 1'b1, 1'b0, 8'h28, 8'h11);
    rx_one(9'h033, 8, 1'b0, 1'b0, 8'h22, 8'h33);
    rx_one(9'h00f, 8, 1'b1, 1'b1, 8'h24, 8'h0f);
    put(A1, 8'h10);
    rx_one(9'h1c3, 9, 1'b1, 1'b0, 8'h20, 8'hc3);
    get(A1, v);
    check(v[7], 1'b1);
    // A quiet line for a whole frame after a character raises the idle flag
    repeat (200) @(negedge clk);
    get(AS, v);
    check(v[4], 1'b1);
  endtask
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Reset for six cycles, then the scenarios in turn
  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    cpu_irq_mask = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    final_report();
  end
endmodule
`default_nettype wire
